// File: verilog/apcs_pkg.sv
// Shared constants and encodings of the pin-driven converter sequencer
package apcs_pkg;

    // ----------------------------------------------------------------
    // Operating modes and output layouts
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        APCS_HI_SPEED  = 2'b00,
        APCS_HI_RES    = 2'b01,
        APCS_LOW_POWER = 2'b10,
        APCS_LOW_SPEED = 2'b11
    } apcs_mode_e;

    typedef enum logic [2:0] {
        APCS_SPI_DYN  = 3'b000,
        APCS_SPI_FIX  = 3'b001,
        APCS_SPI_DISC = 3'b010,
        APCS_FRM_DYN  = 3'b011,
        APCS_FRM_FIX  = 3'b100,
        APCS_FRM_DISC = 3'b101,
        APCS_MOD_OUT  = 3'b110,
        APCS_UNUSED   = 3'b111
    } apcs_layout_e;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int CHANNELS = 8;
    localparam int WORD_BITS = 24;
    localparam int BUF_DEPTH = 2;
    localparam int CONV_W = 12;
    localparam int SETTLE_W = 8;

    // ----------------------------------------------------------------
    // Master clock cycles per conversion, and rate limits per mode
    // ----------------------------------------------------------------
    localparam int RATIO_HS = 256;
    localparam int RATIO_HR = 512;
    localparam int RATIO_LP = 512;
    localparam int RATIO_LS = 2560;
    localparam int SPS_MAX_HS = 144531;
    localparam int SPS_MAX_LS = 10547;
    localparam int MCLK_MAX_HS_MHZ = 37;
    localparam int MCLK_MAX_MHZ = 27;

    // ----------------------------------------------------------------
    // Latencies in conversions, pulse widths in master clock cycles
    // ----------------------------------------------------------------
    localparam int SETTLE_SPI = 129;
    localparam int SETTLE_FRM = 128;
    localparam int WAKE_SPI = 130;
    localparam int WAKE_FRM = 129;
    localparam int SLEEP_MIN_CYC = 2;
    localparam int RESTART_MIN_CYC = 1;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_RST = 2'b00;
    localparam logic [2:0] LAYOUT_RST = 3'b000;

endpackage : apcs_pkg

// File: verilog/apcs_frame_buf.sv
// Two-entry frame buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module apcs_frame_buf #(
    parameter int WIDTH = 192,
    parameter int DEPTH = apcs_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("apcs_frame_buf needs DEPTH >= 2 and WIDTH >= 1");
        end
    endgenerate

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic in_ready;
        logic out_valid;
    } apcs_buf_s;

    apcs_buf_s s_r;
    apcs_buf_s s_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && s_r.in_ready;
    assign pop = s_r.out_valid && out_ready;

    function automatic logic [PW-1:0] apcs_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : apcs_inc

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wp = apcs_inc(s_r.wp);
        end
        if (pop) begin
            s_nxt.rp = apcs_inc(s_r.rp);
        end
        s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
        // Ready is registered from the next count, so it falls in the same cycle the buffer fills
        s_nxt.in_ready = s_nxt.cnt < (PW+1)'(DEPTH);
        s_nxt.out_valid = s_nxt.cnt != '0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '{wp: '0, rp: '0, cnt: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[s_r.wp] <= in_data;
        end
    end

    assign in_ready = s_r.in_ready;
    assign out_valid = s_r.out_valid;
    assign out_data = mem_r[s_r.rp];

endmodule : apcs_frame_buf
`default_nettype wire

// File: verilog/apcs_sequencer.sv
// Mode, restart, channel sleep and output layout sequencing of the converter
//
// Behaviour
// - Mode pins choose conversion ratio per mode.
// - SPI: valid flag high until settled.
// - Frame: lanes low until settled.
// - Frame settling counted on frame strobe edges.
// - Restart low halts and clears counters.
// - Restart sampled on master clock, 1 cycle.
// - SPI: restart forces valid flag high.
// - Frame: restart forces lanes low.
// - One counter and restart for all channels.
// - Two low cycles sleep a channel.
// - All asleep turns biasing off.
// - All asleep forces valid pin high.
// - Woken channel valid after wake latency.
// - Waking leaves running channels undisturbed.
// - Sleeping slot zero, or packed when dynamic.
// - Dynamic frame includes woken channel once valid.
// - Layout pins choose protocol and arrangement.
// - Mode pins watched continuously.
// - Valid flag clears on bit clock fall.
`timescale 1ns/10ps
`default_nettype none
module apcs_sequencer #(
    parameter int N = apcs_pkg::CHANNELS,
    parameter int W = apcs_pkg::WORD_BITS
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [1:0] MODE,
    input wire logic RESTART_N,
    input wire logic [N-1:0] CHANNEL_SLEEP_N,
    input wire logic [2:0] LAYOUT_SEL,
    input wire logic FRAME_STROBE,
    input wire logic BIT_CLOCK,
    input wire logic [N*W-1:0] SAMPLE_DATA,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire logic [N-1:0] MOD_BITS,
    output logic RESULT_VALID_N,
    output logic RESULT_VALID_OE_N,
    output logic [N-1:0] SERIAL_OUT_LANES,
    output logic BIAS_EN,
    output logic [N-1:0] CHANNEL_READY
);
    localparam int CW = apcs_pkg::CONV_W;
    localparam int SW = apcs_pkg::SETTLE_W;

    generate
        if (N < 1 || N > 8 || W < 2) begin : g_bad
            $error("apcs_sequencer serves 1 to 8 channels of at least 2 bits");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode_m1;
        logic [1:0] mode_s;
        logic [1:0] mode_last;
        logic rst_m1;
        logic rst_s;
        logic [N-1:0] slp_m1;
        logic [N-1:0] slp_s;
        logic [N-1:0] slp_prev;
        logic [2:0] lay_m1;
        logic [2:0] lay_s;
        logic fs_m1;
        logic fs_s;
        logic fs_d;
        logic bc_m1;
        logic bc_s;
        logic bc_d;
        logic [CW-1:0] conv_cnt;
        logic [SW-1:0] glob_cnt;
        logic glob_done;
        logic [N-1:0][SW-1:0] ch_cnt;
        logic [N-1:0] asleep;
        logic [N-1:0] ch_ok;
        logic [N*W-1:0] shreg;
        logic pend;
        logic rv_n;
        logic oe_n;
        logic [N-1:0] lanes;
        logic bias_en;
        logic [N-1:0] ready;
    } apcs_state_s;

    apcs_state_s s_r;
    apcs_state_s s_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [CW-1:0] apcs_ratio(input logic [1:0] m);
        case (apcs_pkg::apcs_mode_e'(m))
            apcs_pkg::APCS_HI_SPEED: return CW'(apcs_pkg::RATIO_HS);
            apcs_pkg::APCS_HI_RES: return CW'(apcs_pkg::RATIO_HR);
            apcs_pkg::APCS_LOW_POWER: return CW'(apcs_pkg::RATIO_LP);
            apcs_pkg::APCS_LOW_SPEED: return CW'(apcs_pkg::RATIO_LS);
            default: return CW'(apcs_pkg::RATIO_HS);
        endcase
    endfunction : apcs_ratio

    // Channel i arrives at d[i*W +: W]; slot j leaves from the top downwards
    function automatic logic [N*W-1:0] apcs_pack(input logic [N*W-1:0] d,
                                                 input logic [N-1:0] ok, input logic dyn);
        logic [N*W-1:0] r;
        int k;
        r = '0;
        k = 0;
        for (int i = 0; i < N; i++) begin
            if (ok[i]) begin
                r[(N-1-(dyn ? k : i))*W +: W] = d[i*W +: W];
                k++;
            end
        end
        return r;
    endfunction : apcs_pack

    function automatic logic [N*W-1:0] apcs_shift(input logic [N*W-1:0] sh,
                                                  input logic disc);
        logic [N*W-1:0] r;
        r = {sh[N*W-2:0], 1'b0};
        if (disc) begin
            for (int i = 0; i < N; i++) begin
                r[i*W +: W] = {sh[i*W +: W-1], 1'b0};
            end
        end
        return r;
    endfunction : apcs_shift

    function automatic logic [N-1:0] apcs_lanes(input logic [N*W-1:0] sh,
                                                input logic disc);
        logic [N-1:0] r;
        r = '0;
        r[0] = sh[N*W-1];
        if (disc) begin
            for (int i = 0; i < N; i++) begin
                r[i] = sh[(N-1-i)*W + W-1];
            end
        end
        return r;
    endfunction : apcs_lanes

    // ----------------------------------------------------------------
    // Decode of synchronised pins
    // ----------------------------------------------------------------
    logic is_spi;
    logic is_frm;
    logic is_mod;
    logic is_dyn;
    logic is_disc;
    logic fs_rise;
    logic bc_fall;
    logic mode_chg;
    logic tick;
    logic load;
    logic buf_take;
    logic buf_valid;
    logic [N*W-1:0] buf_data;
    logic [N-1:0] valid_ch;
    logic [SW-1:0] settle_tgt;
    logic [SW-1:0] wake_tgt;

    always_comb begin
        is_spi = 1'b0;
        is_frm = 1'b0;
        is_mod = 1'b0;
        is_dyn = 1'b0;
        is_disc = 1'b0;
        case (apcs_pkg::apcs_layout_e'(s_r.lay_s))
            apcs_pkg::APCS_SPI_DYN: begin
                is_spi = 1'b1;
                is_dyn = 1'b1;
            end
            apcs_pkg::APCS_SPI_FIX: is_spi = 1'b1;
            apcs_pkg::APCS_SPI_DISC: begin
                is_spi = 1'b1;
                is_disc = 1'b1;
            end
            apcs_pkg::APCS_FRM_DYN: begin
                is_frm = 1'b1;
                is_dyn = 1'b1;
            end
            apcs_pkg::APCS_FRM_FIX: is_frm = 1'b1;
            apcs_pkg::APCS_FRM_DISC: begin
                is_frm = 1'b1;
                is_disc = 1'b1;
            end
            apcs_pkg::APCS_MOD_OUT: is_mod = 1'b1;
            // Code 111 is undefined; the valid pin is disabled, but lane 0 still shifts out data once settled
            default: is_mod = 1'b0;
        endcase
    end

    assign fs_rise = s_r.fs_s && !s_r.fs_d;
    assign bc_fall = s_r.bc_d && !s_r.bc_s;
    assign mode_chg = s_r.mode_s != s_r.mode_last;
    // Frame protocol paces conversions by the strobe, so a strobe-aligned
    // change always sees the same count and an unaligned one may slip by one
    assign tick = s_r.rst_s && (is_frm ? fs_rise
                                : s_r.conv_cnt == apcs_ratio(s_r.mode_s) - CW'(1));
    assign load = tick && buf_valid;
    // Halted conversion flushes stale words instead of stalling the source
    assign buf_take = load || !s_r.rst_s;
    assign valid_ch = ~s_r.asleep & s_r.ch_ok & {N{s_r.glob_done}};
    assign settle_tgt = is_spi ? SW'(apcs_pkg::SETTLE_SPI) : SW'(apcs_pkg::SETTLE_FRM);
    assign wake_tgt = is_spi ? SW'(apcs_pkg::WAKE_SPI) : SW'(apcs_pkg::WAKE_FRM);

    apcs_frame_buf #(
        .WIDTH(N*W),
        .DEPTH(apcs_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(SYS_CLK),
        .srst(SRST),
        .in_valid(SAMPLE_VALID),
        .in_ready(SAMPLE_READY),
        .in_data(SAMPLE_DATA),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.mode_m1 = MODE;
        s_nxt.mode_s = s_r.mode_m1;
        s_nxt.rst_m1 = RESTART_N;
        s_nxt.rst_s = s_r.rst_m1;
        s_nxt.slp_m1 = CHANNEL_SLEEP_N;
        s_nxt.slp_s = s_r.slp_m1;
        s_nxt.slp_prev = s_r.slp_s;
        s_nxt.lay_m1 = LAYOUT_SEL;
        s_nxt.lay_s = s_r.lay_m1;
        s_nxt.fs_m1 = FRAME_STROBE;
        s_nxt.fs_s = s_r.fs_m1;
        s_nxt.fs_d = s_r.fs_s;
        s_nxt.bc_m1 = BIT_CLOCK;
        s_nxt.bc_s = s_r.bc_m1;
        s_nxt.bc_d = s_r.bc_s;

        // One counter paces every channel, keeping them aligned
        if (!s_r.rst_s || tick) begin
            s_nxt.conv_cnt = '0;
        end else begin
            s_nxt.conv_cnt = s_r.conv_cnt + CW'(1);
        end

        if (!s_r.rst_s || mode_chg) begin
            s_nxt.glob_cnt = '0;
            s_nxt.glob_done = 1'b0;
            s_nxt.mode_last = s_r.mode_s;
            s_nxt.ch_ok = '1;
        end else if (tick && !s_r.glob_done) begin
            s_nxt.glob_cnt = s_r.glob_cnt + SW'(1);
            s_nxt.glob_done = s_nxt.glob_cnt == settle_tgt;
        end

        for (int i = 0; i < N; i++) begin
            if (!s_r.slp_s[i] && !s_r.slp_prev[i]) begin
                s_nxt.asleep[i] = 1'b1;
                s_nxt.ch_ok[i] = 1'b0;
                s_nxt.ch_cnt[i] = '0;
            end else if (s_r.slp_s[i]) begin
                s_nxt.asleep[i] = 1'b0;
                if (s_r.asleep[i]) begin
                    s_nxt.ch_ok[i] = 1'b0;
                    s_nxt.ch_cnt[i] = '0;
                end else if (tick && !s_r.ch_ok[i]) begin
                    s_nxt.ch_cnt[i] = s_r.ch_cnt[i] + SW'(1);
                    s_nxt.ch_ok[i] = s_nxt.ch_cnt[i] == wake_tgt;
                end
            end
        end

        // Mask from the next state, so the frame that completes settling carries data
        s_nxt.ready = ~s_nxt.asleep & s_nxt.ch_ok & {N{s_nxt.glob_done}};

        // Serialiser: load a frame per conversion, shift on bit clock falls
        s_nxt.pend = 1'b0;
        if (tick) begin
            s_nxt.rv_n = 1'b1;
        end
        if (load) begin
            s_nxt.shreg = apcs_pack(buf_data, s_nxt.ready, is_dyn);
            s_nxt.pend = is_spi;
        end else if (bc_fall) begin
            s_nxt.shreg = apcs_shift(s_r.shreg, is_disc);
            s_nxt.rv_n = 1'b1;
        end
        if (s_r.pend) begin
            s_nxt.rv_n = 1'b0;
        end
        if (!is_spi || !s_r.rst_s || !s_r.glob_done || valid_ch == '0) begin
            s_nxt.rv_n = 1'b1;
        end
        if (&s_r.asleep) begin
            s_nxt.rv_n = 1'b1;
        end
        s_nxt.oe_n = !is_spi;

        if (is_mod) begin
            s_nxt.lanes = MOD_BITS & ~s_r.asleep;
        end else if (!s_r.rst_s || !s_r.glob_done) begin
            s_nxt.lanes = '0;
        end else begin
            s_nxt.lanes = apcs_lanes(s_nxt.shreg, is_disc);
        end

        // Outputs stay driven; only the analog bias follows the sleep state
        s_nxt.bias_en = !(&s_nxt.asleep);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            s_r <= '0;
            s_r.mode_m1 <= apcs_pkg::MODE_RST;
            s_r.mode_s <= apcs_pkg::MODE_RST;
            s_r.mode_last <= apcs_pkg::MODE_RST;
            s_r.lay_m1 <= apcs_pkg::LAYOUT_RST;
            s_r.lay_s <= apcs_pkg::LAYOUT_RST;
            s_r.rst_m1 <= 1'b1;
            s_r.rst_s <= 1'b1;
            s_r.slp_m1 <= '1;
            s_r.slp_s <= '1;
            s_r.slp_prev <= '1;
            s_r.ch_ok <= '1;
            s_r.rv_n <= 1'b1;
            s_r.bias_en <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RESULT_VALID_N = s_r.rv_n;
    assign RESULT_VALID_OE_N = s_r.oe_n;
    assign SERIAL_OUT_LANES = s_r.lanes;
    assign BIAS_EN = s_r.bias_en;
    assign CHANNEL_READY = s_r.ready;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_restart_valid_hi: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (is_spi && !s_r.rst_s) |=> RESULT_VALID_N)
        else $error("valid flag low while restart held");
    chk_restart_lanes_low: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (is_frm && !s_r.rst_s) |=> (SERIAL_OUT_LANES == '0))
        else $error("lanes active while restart held");
    chk_settle_valid_hi: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (is_spi && !s_r.glob_done) |=> RESULT_VALID_N)
        else $error("valid flag low before settling");
    chk_settle_lanes_low: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (is_frm && !s_r.glob_done) |=> (SERIAL_OUT_LANES == '0))
        else $error("lanes active before settling");
    chk_mode_change_resettle: assert property (@(posedge SYS_CLK) disable iff (SRST)
        mode_chg |=> (!s_r.glob_done && s_r.glob_cnt == '0 && !mode_chg))
        else $error("mode change did not restart settling");
    chk_restart_halts: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (!s_r.rst_s ##1 !s_r.rst_s) |-> (s_r.conv_cnt == '0 && !tick))
        else $error("conversion ran during restart");
    chk_sleep_entry: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (!s_r.slp_s[0] && !s_r.slp_prev[0]) |=> (s_r.asleep[0] && !CHANNEL_READY[0]))
        else $error("channel did not sleep after two low cycles");
    chk_all_sleep_valid: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (&s_r.asleep) |=> RESULT_VALID_N)
        else $error("valid flag low with all channels asleep");
    chk_all_sleep_bias: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (&s_r.asleep) |-> !BIAS_EN)
        else $error("bias on with all channels asleep");
    chk_bclk_clears_valid: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (is_spi && !RESULT_VALID_N && bc_fall) |=> RESULT_VALID_N)
        else $error("valid flag not cleared by bit clock fall");

endmodule : apcs_sequencer
`default_nettype wire

// File: tb/apcs_host_model.sv
// Host model: runs the frame strobe and bit clock and counts frames
`timescale 1ns/10ps
`default_nettype none
module apcs_host_model (
    input wire logic run,
    output var logic bit_clock,
    output wire logic frame_strobe,
    output var int frames
);
    logic [1:0] phase = 2'b00;
    int frame_cnt = 0;

    // Bit clock and strobe stop together, so a stop calls for a fresh restart
    initial begin
        bit_clock = 1'b0;
        forever begin
            #40;
            bit_clock = run & ~bit_clock;
        end
    end

    // Four bit clocks a frame: enough to prove framing, far shorter than a real frame
    always @(posedge bit_clock) begin
        phase <= phase + 2'b01;
        if (phase == 2'b01) begin
            frame_cnt <= frame_cnt + 1;
        end
    end

    assign frames = frame_cnt;
    assign frame_strobe = run & phase[1];
endmodule : apcs_host_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the converter pin sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [1:0] MODE = 2'b00;
    logic RESTART_N = 1'b0;
    logic [7:0] CHANNEL_SLEEP_N = 8'hff;
    logic [2:0] LAYOUT_SEL = 3'b100;
    logic [191:0] SAMPLE_DATA = {192{1'b1}};
    logic SAMPLE_VALID = 1'b0;
    logic [7:0] MOD_BITS = 8'h00;
    logic run = 1'b0;
    wire logic FRAME_STROBE;
    logic BIT_CLOCK, SAMPLE_READY, RESULT_VALID_N, RESULT_VALID_OE_N, BIAS_EN;
    logic [7:0] SERIAL_OUT_LANES, CHANNEL_READY;
    int frames;
    int err_count = 0;
    int n_checks = 0;

    apcs_sequencer uut (.SYS_CLK(SYS_CLK), .SRST(SRST), .MODE(MODE), .RESTART_N(RESTART_N),
        .CHANNEL_SLEEP_N(CHANNEL_SLEEP_N), .LAYOUT_SEL(LAYOUT_SEL),
        .FRAME_STROBE(FRAME_STROBE), .BIT_CLOCK(BIT_CLOCK), .SAMPLE_DATA(SAMPLE_DATA),
        .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .MOD_BITS(MOD_BITS),
        .RESULT_VALID_N(RESULT_VALID_N), .RESULT_VALID_OE_N(RESULT_VALID_OE_N),
        .SERIAL_OUT_LANES(SERIAL_OUT_LANES), .BIAS_EN(BIAS_EN), .CHANNEL_READY(CHANNEL_READY));

    apcs_host_model host (.run(run), .bit_clock(BIT_CLOCK), .frame_strobe(FRAME_STROBE),
        .frames(frames));

    always #4 SYS_CLK = ~SYS_CLK;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : cyc

    task automatic test_done();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_span(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : check_span

    // Frames until the ready mask shows; kept channels must hold, lanes stay low if none kept
    task automatic settle(input logic [7:0] want, input logic [7:0] keep, input int lo,
                          input int hi);
        int f0;
        int i;
        int bad;
        f0 = frames;
        bad = 0;
        for (i = 0; i < 30000 && CHANNEL_READY !== want; i++) begin
            if ((CHANNEL_READY & keep) !== keep) bad++;
            if (keep == 8'h00 && SERIAL_OUT_LANES !== 8'h00) bad++;
            cyc(1);
        end
        check(bad[7:0], 8'h00);
        check_span(frames - f0, lo, hi);
        if (i == 30000) test_done();
    endtask : settle

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_buffer();
        int pushes;
        int i;
        pushes = 0;
        SAMPLE_VALID = 1'b1;
        repeat (6) begin
            if (SAMPLE_READY === 1'b1) pushes++;
            cyc(1);
        end
        check(pushes[7:0], 8'h02);
        run = 1'b1;
        for (i = 0; i < 400 && SAMPLE_READY !== 1'b1; i++) cyc(1);
        check({7'h0, SAMPLE_READY}, 8'h01);
        if (i == 400) test_done();
    endtask : s_buffer

    task automatic s_restart();
        int i;
        RESTART_N = 1'b0; // Power-on restart pulse, clocks already running
        cyc(4); // Held well past one clock
        check(SERIAL_OUT_LANES, 8'h00);
        check(CHANNEL_READY, 8'h00);
        RESTART_N = 1'b1;
        settle(8'hff, 8'h00, 127, 129);
        // Host polls lane 0 for its first one
        for (i = 0; i < 400 && SERIAL_OUT_LANES[0] !== 1'b1; i++) cyc(1);
        check({7'h0, SERIAL_OUT_LANES[0]}, 8'h01);
        if (i == 400) test_done();
    endtask : s_restart

    task automatic s_modes();
        int m;
        for (m = 1; m < 5; m++) begin
            MODE = m[1:0]; // Applied off the strobe, at any frame phase
            cyc(4);
            check(CHANNEL_READY, 8'h00);
            settle(8'hff, 8'h00, 127, 129);
        end
    endtask : s_modes

    task automatic s_sleep();
        CHANNEL_SLEEP_N = 8'hf7;
        cyc(5);
        check(CHANNEL_READY, 8'hf7);
        CHANNEL_SLEEP_N = 8'hff; // Raised with the strobe running
        settle(8'hff, 8'hf7, 128, 130);
    endtask : s_sleep

    task automatic s_layout();
        int c;
        int i;
        int lo;
        int hi;
        MOD_BITS = 8'h5a;
        for (c = 0; c < 7; c++) begin
            LAYOUT_SEL = c[2:0]; // Code 111 is never driven
            cyc(5);
            check({7'h0, RESULT_VALID_OE_N}, {7'h0, c > 2});
            if (c == 6) check(SERIAL_OUT_LANES, 8'h5a);
        end
        LAYOUT_SEL = 3'b001;
        RESTART_N = 1'b0;
        cyc(4);
        check({7'h0, RESULT_VALID_N}, 8'h01);
        RESTART_N = 1'b1;
        cyc(20);
        check({7'h0, RESULT_VALID_N}, 8'h01);
        // Settled data in SPI: the flag falls, then a bit clock fall clears it
        for (i = 0; i < 40000 && RESULT_VALID_N !== 1'b0; i++) cyc(1);
        lo = (apcs_pkg::SETTLE_SPI - 2) * apcs_pkg::RATIO_HS;
        hi = (apcs_pkg::SETTLE_SPI + 1) * apcs_pkg::RATIO_HS;
        check_span(i + 20, lo, hi);
        if (i == 40000) test_done();
        for (i = 0; i < 20 && RESULT_VALID_N !== 1'b1; i++) cyc(1);
        check({7'h0, RESULT_VALID_N}, 8'h01);
        CHANNEL_SLEEP_N = 8'h00;
        cyc(5);
        check({6'h0, BIAS_EN, RESULT_VALID_N}, 8'h01);
    endtask : s_layout

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(5);
        check(CHANNEL_READY | SERIAL_OUT_LANES, 8'h00);
        check({5'h0, BIAS_EN, RESULT_VALID_N, SAMPLE_READY}, 8'h07);
        @(posedge SYS_CLK);
        #1;
        SRST = 1'b0;
        RESTART_N = 1'b1;
        s_buffer();
        s_restart();
        s_modes();
        s_sleep();
        s_layout();
        test_done();
    end
endmodule : testbench
`default_nettype wire
